// >>> hdl/wdt_pkg.sv
// package of constants and carriers for the windowed watchdog supervisor
package wdt_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_NS          = 20;
    localparam int unsigned CNT_W           = 32;

    // slow fault limit, fixed option: plain default, set per build
    localparam int unsigned SLOW_FIXED_MS   = 250;
    localparam int unsigned SLOW_FIXED_CYC  = SLOW_FIXED_MS * (CLK_HZ / 1000);
    // adjustable option: 155e6 s/F times capacitance; capacitance in pF
    localparam int unsigned SLOW_SCALE_MEG  = 155;
    localparam int unsigned CAP_PF_DEFAULT  = 2000;
    // 155e6 * C[pF] * 1e-12 s = 155 * C / 1e6 s; in cycles: 155 * C * 50
    localparam int unsigned SLOW_ADJ_CYC    = SLOW_SCALE_MEG * CAP_PF_DEFAULT
                                              * (CLK_HZ / 1_000_000);

    // reset hold period options, in ns
    localparam int unsigned HOLD_D0_NS      = 35_000;
    localparam int unsigned HOLD_D1_NS      = 3_125_000;
    localparam int unsigned HOLD_D2_NS      = 12_500_000;
    localparam int unsigned HOLD_D3_NS      = 50_000_000;
    localparam int unsigned HOLD_D4_NS      = 200_000_000;
    localparam int unsigned HOLD_D2_CYC     = HOLD_D2_NS / CLK_NS;

    // ****************************************************************
    // window ratio encoding
    // ****************************************************************
    localparam logic [1:0]  SEL_R8          = 2'h0;
    localparam logic [1:0]  SEL_R16         = 2'h1;
    localparam logic [1:0]  SEL_OFF         = 2'h2;
    localparam logic [1:0]  SEL_R64         = 2'h3;
    localparam int unsigned SHIFT_R8        = 3;
    localparam int unsigned SHIFT_R16       = 4;
    localparam int unsigned SHIFT_R64       = 6;

    // synchronised strap and enable levels
    typedef struct packed {
        logic       windowed;
        logic       adjustable;
        logic [1:0] ratio_sel;
        logic       check_off_n;
        logic       light_load;
        logic       load_above;
    } cfg_s;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'h1,
        ST_ARM   = 3'h2,
        ST_WATCH = 3'h4
    } wd_state_e;

endpackage : wdt_pkg

// >>> hdl/sync2.sv
// two-flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire  logic         clk,
    input  wire  logic [W-1:0] d,
    output var   logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end
endmodule : sync2
`default_nettype wire

// >>> hdl/windowed_watchdog_supervisor.sv
// windowed watchdog supervisor: strobe interval check and reset pulse
// What this block does
// - slow limit fixed or adjustable by strap
// - adjustable limit scales with timing capacitance
// - interval too short or too long faults
// - fault drives reset low for hold period
// - fast limit is slow limit over ratio
// - select a high, b low disables watchdog
// - strobe ignored while reset asserted
// - measuring starts only after reset release
// - interval counter cleared when reset asserts
// - non-windowed: disable pin low disables watchdog
// - light load disables the watchdog
// - light-load disable released only above upper threshold
// - re-enable immediately unless reset asserted
// - hold period one of five build values
// - select encoding 8, 16, off, 64
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_supervisor #(
    parameter int unsigned             CNT_W      = wdt_pkg::CNT_W,
    parameter logic [wdt_pkg::CNT_W-1:0] SLOW_FIXED = wdt_pkg::CNT_W'(wdt_pkg::SLOW_FIXED_CYC),
    parameter logic [wdt_pkg::CNT_W-1:0] SLOW_ADJ   = wdt_pkg::CNT_W'(wdt_pkg::SLOW_ADJ_CYC),
    parameter logic [wdt_pkg::CNT_W-1:0] HOLD_CYC   = wdt_pkg::CNT_W'(wdt_pkg::HOLD_D2_CYC),
    parameter bit                      WINDOWED   = 1'b1
) (
    input  wire  logic CLOCK,
    input  wire  logic RST,
    input  wire  logic HOST_STROBE_IN,
    input  wire  logic TIMEOUT_CAP_PIN,
    input  wire  logic WINDOW_RATIO_SEL_A,
    input  wire  logic WINDOW_RATIO_SEL_B,
    input  wire  logic STROBE_CHECK_OFF_N,
    input  wire  logic LOAD_BELOW_DISABLE,
    input  wire  logic LOAD_ABOVE_ENABLE,
    output var   logic RESET_OUT_N,
    output var   logic WATCHDOG_ACTIVE,
    output var   logic FAULT_FAST,
    output var   logic FAULT_SLOW
);

    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    logic [6:0] raw_in;
    logic [6:0] sync_in;
    logic       strobe_s;
    logic       strobe_d;
    wdt_pkg::cfg_s cfg;

    assign raw_in = {HOST_STROBE_IN, TIMEOUT_CAP_PIN, WINDOW_RATIO_SEL_A,
                     WINDOW_RATIO_SEL_B, STROBE_CHECK_OFF_N, LOAD_BELOW_DISABLE,
                     LOAD_ABOVE_ENABLE};

    sync2 #(.W(7)) u_sync (
        .clk (CLOCK),
        .d   (raw_in),
        .q   (sync_in)
    );

    assign strobe_s        = sync_in[6];
    assign cfg.windowed    = WINDOWED;
    assign cfg.adjustable  = ~sync_in[5];
    assign cfg.ratio_sel   = sync_in[4:3];
    assign cfg.check_off_n = sync_in[2];
    assign cfg.light_load  = sync_in[1];
    assign cfg.load_above  = sync_in[0];

    // ****************************************************************
    // configuration captured at reset release
    // ****************************************************************
    logic             cfg_taken;
    logic [CNT_W-1:0] slow_limit;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_taken  <= 1'b0;
            slow_limit <= SLOW_FIXED;
        end else if (!cfg_taken) begin
            cfg_taken  <= 1'b1;
            // strap low selects capacitor timing, tied high selects fixed
            slow_limit <= cfg.adjustable ? SLOW_ADJ : SLOW_FIXED;
        end
    end

    // fast limit as slow limit divided by the selected ratio
    function automatic logic [CNT_W-1:0] fast_of(input logic [CNT_W-1:0] slow,
                                                  input logic [1:0]       sel);
        logic [CNT_W-1:0] r;
        r = '0;
        unique case (sel)
            wdt_pkg::SEL_R8:  r = slow >> wdt_pkg::SHIFT_R8;
            wdt_pkg::SEL_R16: r = slow >> wdt_pkg::SHIFT_R16;
            wdt_pkg::SEL_R64: r = slow >> wdt_pkg::SHIFT_R64;
            wdt_pkg::SEL_OFF: r = '0;
        endcase
        return r;
    endfunction : fast_of

    logic [CNT_W-1:0] fast_limit;
    assign fast_limit = cfg.windowed ? fast_of(slow_limit, cfg.ratio_sel) : '0;

    // ****************************************************************
    // disable conditions
    // ****************************************************************
    logic light_off;
    logic disabled;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            light_off <= 1'b0;
        end else if (cfg.light_load) begin
            light_off <= 1'b1;
        end else if (cfg.load_above) begin
            light_off <= 1'b0;
        end
    end

    assign disabled = light_off
                    | (cfg.windowed && cfg.ratio_sel == wdt_pkg::SEL_OFF)
                    | (!cfg.windowed && !cfg.check_off_n);

    // ****************************************************************
    // interval measurement and reset hold
    // ****************************************************************
    wdt_pkg::wd_state_e state;
    logic [CNT_W-1:0]   interval;
    logic [CNT_W-1:0]   hold_cnt;
    logic               edge_seen;
    logic               too_fast;
    logic               too_slow;

    assign edge_seen = strobe_s ^ strobe_d;
    assign too_fast  = edge_seen && (interval < fast_limit);
    assign too_slow  = (interval >= slow_limit);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            strobe_d <= 1'b0;
        end else begin
            strobe_d <= strobe_s;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state       <= wdt_pkg::ST_HOLD;
            interval    <= '0;
            hold_cnt    <= '0;
            RESET_OUT_N <= 1'b0;
            FAULT_FAST  <= 1'b0;
            FAULT_SLOW  <= 1'b0;
        end else begin
            FAULT_FAST <= 1'b0;
            FAULT_SLOW <= 1'b0;
            unique case (state)
                wdt_pkg::ST_HOLD: begin
                    interval <= '0;
                    if (hold_cnt >= HOLD_CYC - 1'b1) begin
                        hold_cnt    <= '0;
                        RESET_OUT_N <= 1'b1;
                        state       <= wdt_pkg::ST_ARM;
                    end else begin
                        hold_cnt <= hold_cnt + 1'b1;
                    end
                end
                wdt_pkg::ST_ARM, wdt_pkg::ST_WATCH: begin
                    if (disabled) begin
                        interval <= '0;
                        state    <= wdt_pkg::ST_ARM;
                    end else if (too_fast || too_slow) begin
                        FAULT_FAST  <= too_fast;
                        FAULT_SLOW  <= too_slow & ~too_fast;
                        RESET_OUT_N <= 1'b0;
                        interval    <= '0;
                        hold_cnt    <= '0;
                        state       <= wdt_pkg::ST_HOLD;
                    end else begin
                        state    <= wdt_pkg::ST_WATCH;
                        interval <= edge_seen ? CNT_W'(1) : interval + 1'b1;
                    end
                end
                default: begin
                    state <= wdt_pkg::ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            WATCHDOG_ACTIVE <= 1'b0;
        end else begin
            WATCHDOG_ACTIVE <= (state != wdt_pkg::ST_HOLD) && !disabled;
        end
    end

endmodule : windowed_watchdog_supervisor
`default_nettype wire

// >>> tb/wdt_chk.sv
// assertion checker bound to the watchdog supervisor ports
`timescale 1ns/1ps
`default_nettype none
module wdt_chk #(
    parameter int unsigned HOLD = 20,
    parameter int unsigned SLOW = 200
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic HOST_STROBE_IN,
    input wire logic WINDOW_RATIO_SEL_A,
    input wire logic WINDOW_RATIO_SEL_B,
    input wire logic LOAD_BELOW_DISABLE,
    input wire logic RESET_OUT_N,
    input wire logic WATCHDOG_ACTIVE,
    input wire logic FAULT_FAST,
    input wire logic FAULT_SLOW
);
    logic [31:0] low_cnt;
    logic [31:0] quiet_cnt;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    always_ff @(posedge CLOCK) low_cnt <= (RST || RESET_OUT_N) ? 32'h0 : low_cnt + 32'h1;
    always_ff @(posedge CLOCK) quiet_cnt <= (RST || !RESET_OUT_N || !WATCHDOG_ACTIVE
        || $changed(HOST_STROBE_IN)) ? 32'h0 : quiet_cnt + 32'h1;
    hold_len_a: assert property ($rose(RESET_OUT_N) |-> low_cnt + 1 >= HOLD && low_cnt <= HOLD + 1)
        else $error("reset hold length off");
    hold_cap_a: assert property (low_cnt <= HOLD + 1)
        else $error("reset held too long");
    fault_reset_a: assert property ((FAULT_FAST || FAULT_SLOW) |-> ##[0:1] !RESET_OUT_N)
        else $error("fault without reset");
    fault_pulse_a: assert property ((FAULT_FAST || FAULT_SLOW) |=> !FAULT_FAST && !FAULT_SLOW)
        else $error("fault pulse too long");
    slow_due_a: assert property (quiet_cnt <= SLOW + 4)
        else $error("slow fault missing");
    sel_off_a: assert property ((WINDOW_RATIO_SEL_A && !WINDOW_RATIO_SEL_B) [*4] |-> !FAULT_FAST && !FAULT_SLOW)
        else $error("fault while watchdog off");
    light_off_a: assert property (LOAD_BELOW_DISABLE [*4] |=> !WATCHDOG_ACTIVE)
        else $error("active at light load");
    quiet_hold_a: assert property (!RESET_OUT_N && !$past(RESET_OUT_N) |-> !WATCHDOG_ACTIVE)
        else $error("measuring during reset");
endmodule : wdt_chk
bind windowed_watchdog_supervisor wdt_chk #(.HOLD(HOLD_CYC), .SLOW(SLOW_FIXED)) i_wdt_chk (
    .CLOCK(CLOCK), .RST(RST), .HOST_STROBE_IN(HOST_STROBE_IN),
    .WINDOW_RATIO_SEL_A(WINDOW_RATIO_SEL_A), .WINDOW_RATIO_SEL_B(WINDOW_RATIO_SEL_B),
    .LOAD_BELOW_DISABLE(LOAD_BELOW_DISABLE), .RESET_OUT_N(RESET_OUT_N),
    .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE), .FAULT_FAST(FAULT_FAST), .FAULT_SLOW(FAULT_SLOW));
`default_nettype wire

// >>> tb/host_strobe_model.sv
// host model that toggles the watchdog strobe every gap cycles
`timescale 1ns/1ps
`default_nettype none
module host_strobe_model (
    input  wire logic        clock,
    input  wire logic        run,
    input  wire logic [15:0] gap,
    output var  logic        strobe
);
    logic [15:0] count;
    initial strobe = 1'b0;
    always @(posedge clock) begin
        if (!run) count <= 16'h0;
        else if (count + 16'h1 >= gap) begin
            count <= 16'h0;
            strobe <= ~strobe;
        end else count <= count + 16'h1;
    end
endmodule : host_strobe_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking testbench for the windowed watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SLOW = 200;
    localparam int ADJ  = 40;
    localparam int HOLD = 20;
    logic clock, rst, strobe, cap, sel_a, sel_b, chk_n, below, above, run;
    logic rst_n_out, active, f_fast, f_slow;
    logic [15:0] gap;
    int err_count, num_checks, lim;
    int sh[3] = '{3, 4, 6};
    bit sa[3] = '{0, 0, 1};
    bit sb[3] = '{0, 1, 1};
    windowed_watchdog_supervisor #(.SLOW_FIXED(32'hC8), .SLOW_ADJ(32'h28), .HOLD_CYC(32'h14))
    i_windowed_watchdog_supervisor (.CLOCK(clock), .RST(rst), .HOST_STROBE_IN(strobe),
        .TIMEOUT_CAP_PIN(cap), .WINDOW_RATIO_SEL_A(sel_a), .WINDOW_RATIO_SEL_B(sel_b),
        .STROBE_CHECK_OFF_N(chk_n), .LOAD_BELOW_DISABLE(below), .LOAD_ABOVE_ENABLE(above),
        .RESET_OUT_N(rst_n_out), .WATCHDOG_ACTIVE(active), .FAULT_FAST(f_fast),
        .FAULT_SLOW(f_slow));
    host_strobe_model i_host_strobe_model (.clock(clock), .run(run), .gap(gap), .strobe(strobe));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : check
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // reference model: 0 none, 1 fast, 2 slow
    function int exp_code(int g, int slow, int shift, bit off);
        if (off) return 0;
        if (g == 0 || g > slow) return 2;
        if (g < (slow >> shift)) return 1;
        return 0;
    endfunction : exp_code
    task run_case(input bit a, input bit b, input bit c, input bit ll, input int g, input int s);
        int slow, t, code;
        slow = c ? SLOW : ADJ;
        @(posedge clock);
        {sel_a, sel_b, cap, rst, run} <= {a, b, c, 2'h2};
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t = 0;
        while (rst_n_out !== 1'b1 && t < 100) begin
            @(posedge clock);
            #1 t++;
        end
        if (t >= 100) begin
            err_count++;
            complete_run();
        end
        check(32'(t >= HOLD && t <= HOLD + 3), 32'h1);
        if (ll) begin
            @(posedge clock) below <= 1'b1;
            repeat (4) @(posedge clock);
            below <= 1'b0;
            repeat (4) @(posedge clock);
            #1 check(32'(active), 32'h0);
        end
        @(posedge clock) {gap, run} <= {16'(g), g != 0};
        code = 0;
        t = 0;
        while (code == 0 && t < 260) begin
            @(posedge clock);
            #1 t++;
            code = (f_fast === 1'b1) ? 1 : ((f_slow === 1'b1) ? 2 : 0);
        end
        check(32'(code), 32'(exp_code(g, slow, s, (a && !b) || ll)));
        if (code == 2) check(32'(t + 3 >= slow && t <= slow + 6), 32'h1);
        if (ll) begin
            @(posedge clock) above <= 1'b1;
            @(posedge clock) above <= 1'b0;
            repeat (4) @(posedge clock);
            #1 check(32'(active), 32'h1);
        end
        @(posedge clock) run <= 1'b0;
    endtask : run_case
    initial begin
        {rst, sel_a, sel_b, cap, chk_n, below, above, run, gap} = {8'hB0, 16'h0};
        err_count = 0;
        num_checks = 0;
        void'($urandom(47));
        for (int i = 0; i < 3; i++) begin
            lim = SLOW >> sh[i];
            run_case(sa[i], sb[i], 1'b1, 1'b0, lim - 2, sh[i]);
            run_case(sa[i], sb[i], 1'b1, 1'b0, lim + 2, sh[i]);
        end
        run_case(1'b0, 1'b0, 1'b1, 1'b0, 0, 3);
        run_case(1'b0, 1'b0, 1'b0, 1'b0, 0, 3);
        run_case(1'b1, 1'b0, 1'b1, 1'b0, 10, 3);
        run_case(1'b0, 1'b0, 1'b1, 1'b1, 0, 3);
        repeat (4) run_case(1'b0, 1'b0, 1'b1, 1'b0, 30 + $urandom_range(160), 3);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
